/* File: design/ccd_hblank_pkg.sv */
package ccd_hblank_pkg;
  localparam int ADDR_W   = 6;
  localparam int DATA_W   = 26;
  localparam int POS_W    = 13;
  localparam int CNT_W    = 14;
  localparam int OFS_W    = 12;
  localparam int PAT_W    = 3;
  localparam int NUM_SEQ  = 17;
  localparam int NUM_AREA = 6;
  localparam int NUM_GRP  = 4;

  // Register offsets, one word each
  localparam logic [ADDR_W-1:0] OFS_BLANK_START_END   = 6'h17;
  localparam logic [ADDR_W-1:0] OFS_BLANK_LEN_REP     = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_ODD_TOGGLE_1_2    = 6'h19;
  localparam logic [ADDR_W-1:0] OFS_ODD_TOGGLE_3_4    = 6'h1A;
  localparam logic [ADDR_W-1:0] OFS_ODD_TOGGLE_5_6    = 6'h1B;
  localparam logic [ADDR_W-1:0] OFS_EVEN_TOGGLE_1_2   = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_EVEN_TOGGLE_3_4   = 6'h1D;
  localparam logic [ADDR_W-1:0] OFS_EVEN_TOGGLE_5_6   = 6'h1E;
  localparam logic [ADDR_W-1:0] OFS_AREA_START_A_B    = 6'h1F;
  localparam logic [ADDR_W-1:0] OFS_AREA_START_C_MASK = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_AREA_PATTERNS_ODD = 6'h21;
  localparam logic [ADDR_W-1:0] OFS_BLACK_CLAMP_TOG   = 6'h22;
  localparam logic [ADDR_W-1:0] OFS_PREBLANK_TOG      = 6'h23;
  localparam logic [ADDR_W-1:0] OFS_HCLOCK_OFFSET_A   = 6'h24;
  localparam logic [ADDR_W-1:0] OFS_HCLOCK_OFFSET_B   = 6'h25;
  localparam logic [ADDR_W-1:0] OFS_HCLOCK_OFFSET_C   = 6'h26;
  localparam logic [ADDR_W-1:0] OFS_BLANK_CNT_START   = 6'h27;
  localparam logic [ADDR_W-1:0] OFS_CONTROL           = 6'h28;
  localparam logic [ADDR_W-1:0] OFS_STATUS            = 6'h29;

  // Field positions
  localparam int LO_LSB       = 0;
  localparam int HI_LSB       = 13;
  localparam int OFS_HI_LSB   = 12;
  localparam int REP_LSB      = 13;
  localparam int REP_W        = 8;
  localparam int MASK_H1_BIT  = 21;
  localparam int EVEN_MSK_LSB = 13;
  localparam int ODD_MSK_LSB  = 17;
  localparam int PAT_STRIDE   = 4;
  localparam int END_MSB_BIT  = 13;
  localparam int MODE_BIT     = 0;

  // Reset values
  localparam logic [DATA_W-1:0] SEQ_RESET  = 26'h0000000;
  localparam logic              MODE_RESET = 1'b0;
  localparam logic [POS_W-1:0]  NEVER_POS  = 13'h1FFF;

  // Writable bits of each sequence register, index = offset - 0x17
  localparam logic [DATA_W-1:0] SEQ_MASK [NUM_SEQ] = '{
    26'h3FFFFFF, 26'h1FFFFFF, 26'h3FFFFFF, 26'h3FFFFFF, 26'h3FFFFFF, 26'h3FFFFFF,
    26'h3FFFFFF, 26'h3FFFFFF, 26'h3FFFFFF, 26'h01FFFFF, 26'h0777777, 26'h3FFFFFF,
    26'h3FFFFFF, 26'h0FFFFFF, 26'h0FFFFFF, 26'h0FFFFFF, 26'h0003FFF};

  typedef enum logic {BLANK_MODE0, BLANK_MODE1} blank_mode_e;
  typedef enum logic [1:0] {AREA_IDLE, AREA_RUN, AREA_DONE} area_state_e;
endpackage

/* File: design/ccd_line_blanking.sv */
// Implementation choice: strobed register access.
`timescale 1ns/10ps
module ccd_line_blanking
  import ccd_hblank_pkg::*;
(
  input  wire logic                                ref_clk_in,
  input  wire logic                                rst_in,
  input  wire logic                                ce_in,
  input  wire logic [ccd_hblank_pkg::ADDR_W-1:0]   addr_in,
  input  wire logic [ccd_hblank_pkg::DATA_W-1:0]   wdata_in,
  input  wire logic                                wr_in,
  input  wire logic                                rd_in,
  output logic      [ccd_hblank_pkg::DATA_W-1:0]   rdata_out,
  input  wire logic                                line_start_in,
  input  wire logic                                odd_line_in,
  input  wire logic                                seq_change_point_in,
  input  wire logic [ccd_hblank_pkg::POS_W-1:0]    freeze_pos_in,
  input  wire logic [ccd_hblank_pkg::POS_W-1:0]    resume_pos_in,
  output logic                                     horizontal_blanking_out,
  output logic                                     optical_black_clamp_pulse_out,
  output logic                                     preblanking_pulse_out,
  output logic                                     odd_phase_hclocks_out,
  output logic      [ccd_hblank_pkg::NUM_GRP-1:0]  group_frozen_out,
  output logic      [ccd_hblank_pkg::PAT_W-1:0]    repeat_area_pattern_out,
  output logic      [2:0]                          repeat_area_out,
  output logic      [ccd_hblank_pkg::POS_W-1:0]    area_phase2_repeat_count_out,
  output logic      [ccd_hblank_pkg::OFS_W-1:0]    hclock_offset_out
);
  import ccd_hblank_pkg::*;

  logic [DATA_W-1:0]  pend_q [NUM_SEQ];
  logic [DATA_W-1:0]  act_q [NUM_SEQ];
  blank_mode_e        mode_q;
  area_state_e        area_st_q;
  logic [CNT_W-1:0]   hcount_q;
  logic               blank_q;
  logic               cnt_run_q;
  logic [POS_W-1:0]   blank_cnt_q;
  logic [REP_W-1:0]   rep_done_q;
  logic [2:0]         area_q;
  logic [POS_W-1:0]   area_cnt_q;
  logic [1:0]         region_q;
  logic               hblank_q;
  logic               clamp_q;
  logic               preblank_q;
  logic               hclk_q;
  logic [NUM_GRP-1:0] frozen_q;
  logic [DATA_W-1:0]  rdata_q;
  logic [NUM_AREA-1:0] tog_hit;
  logic               seq_hit;
  logic [4:0]         seq_idx;

  // Picks one 13-bit half of an active register
  function automatic logic [POS_W-1:0] half_pos(input logic [DATA_W-1:0] r, input logic hi);
    half_pos = hi ? r[HI_LSB +: POS_W] : r[LO_LSB +: POS_W];
  endfunction

  // Matches a 13-bit position against the line counter
  function automatic logic at_pos(input logic [CNT_W-1:0] cnt, input logic [POS_W-1:0] pos);
    at_pos = (cnt == {1'b0, pos});
  endfunction

  // Register decode for the sequence block
  always_comb begin
    seq_hit = (addr_in >= OFS_BLANK_START_END) && (addr_in <= OFS_BLANK_CNT_START);
    seq_idx = 5'(addr_in - OFS_BLANK_START_END);
  end

  // Field views of the active copy
  logic [POS_W-1:0]   blank_start;
  logic [CNT_W-1:0]   blank_end;
  logic [POS_W-1:0]   blank_len;
  logic [REP_W-1:0]   blank_rep;
  logic               mask_pol_h1;
  logic [POS_W-1:0]   cnt_start;
  logic [NUM_GRP-1:0] grp_mask;
  logic [POS_W-1:0]   phase1_rep;
  logic [POS_W-1:0]   phase2_rep;
  logic [DATA_W-1:0]  offset_reg;
  assign blank_start = half_pos(act_q[0], 1'b0);
  assign blank_end   = {act_q[16][END_MSB_BIT], half_pos(act_q[0], 1'b1)};
  assign blank_len   = half_pos(act_q[1], 1'b0);
  assign blank_rep   = act_q[1][REP_LSB +: REP_W];
  assign mask_pol_h1 = act_q[1][MASK_H1_BIT];
  assign cnt_start   = half_pos(act_q[16], 1'b0);
  // Mask choice follows the line parity
  assign grp_mask    = odd_line_in ? act_q[9][ODD_MSK_LSB +: NUM_GRP]
                                   : act_q[9][EVEN_MSK_LSB +: NUM_GRP];
  // Toggle fields double as per-area repeat counts in mode 1
  assign phase1_rep  = half_pos(act_q[2 + 32'(area_q >> 1)], area_q[0]);
  assign phase2_rep  = half_pos(act_q[5 + 32'(area_q >> 1)], area_q[0]);
  assign offset_reg  = (region_q == 2'd3) ? act_q[15] :
                       (region_q == 2'd2) ? act_q[14] : act_q[13];

  // One match per toggle slot of the current line parity
  for (genvar k = 0; k < NUM_AREA; k++) begin : g_tog
    assign tog_hit[k] = at_pos(hcount_q, half_pos(odd_line_in ? act_q[2 + k/2]
                                                              : act_q[5 + k/2],
                                                  1'(k % 2)));
  end

  // Software copy; writes land here and wait for the change point
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_SEQ; i++) pend_q[i] <= SEQ_RESET;
    end else if (ce_in && wr_in && seq_hit) begin
      pend_q[seq_idx] <= wdata_in & SEQ_MASK[seq_idx];
    end
  end

  // Active copy only moves at a change point, so no line sees a half-written set
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_SEQ; i++) act_q[i] <= SEQ_RESET;
    end else if (ce_in && seq_change_point_in) begin
      for (int i = 0; i < NUM_SEQ; i++) act_q[i] <= pend_q[i];
    end
  end

  // Mode control takes effect at once
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mode_q <= blank_mode_e'(MODE_RESET);
    end else if (ce_in && wr_in && addr_in == OFS_CONTROL) begin
      mode_q <= blank_mode_e'(wdata_in[MODE_BIT]);
    end
  end

  // Read data stands for one cycle only, zero otherwise
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rdata_q <= '0;
    end else if (ce_in) begin
      if (!rd_in) rdata_q <= '0;
      else if (seq_hit) rdata_q <= pend_q[seq_idx];
      else if (addr_in == OFS_CONTROL) rdata_q <= DATA_W'(mode_q);
      else if (addr_in == OFS_STATUS)
        rdata_q <= DATA_W'({area_q, blank_q, hblank_q, clamp_q, preblank_q, frozen_q});
      else rdata_q <= '0;
    end
  end

  // Pixel counter of the current line
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) hcount_q <= '0;
    else if (ce_in) hcount_q <= line_start_in ? '0 : hcount_q + 1'b1;
  end

  // Blanking counter, runs in length periods from its start position
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || (ce_in && line_start_in)) begin
      cnt_run_q   <= 1'b0;
      blank_cnt_q <= '0;
      rep_done_q  <= '0;
    end else if (ce_in) begin
      if (at_pos(hcount_q, cnt_start)) begin
        cnt_run_q   <= 1'b1;
        blank_cnt_q <= '0;
        rep_done_q  <= '0;
      end else if (cnt_run_q) begin
        if (blank_cnt_q + 1'b1 >= blank_len) begin
          blank_cnt_q <= '0;
          rep_done_q  <= rep_done_q + 1'b1;
        end else begin
          blank_cnt_q <= blank_cnt_q + 1'b1;
        end
      end
    end
  end

  // Blanking interval: start to end, cut short once the repetitions run out
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || (ce_in && line_start_in)) begin
      blank_q <= 1'b0;
    end else if (ce_in) begin
      if (at_pos(hcount_q, blank_start)) blank_q <= 1'b1;
      else if (hcount_q == blank_end) blank_q <= 1'b0;
      else if (cnt_run_q && blank_rep != '0 && rep_done_q >= blank_rep) blank_q <= 1'b0;
    end
  end

  // Blanking output: toggle list in mode 0, interval itself in mode 1
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || (ce_in && line_start_in)) begin
      hblank_q <= 1'b0;
    end else if (ce_in) begin
      if (mode_q == BLANK_MODE0) hblank_q <= hblank_q ^ (^tog_hit);
      else hblank_q <= blank_q;
    end
  end

  // Clamp and preblank pulses; coinciding positions cancel
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || (ce_in && line_start_in)) begin
      clamp_q    <= 1'b0;
      preblank_q <= 1'b0;
    end else if (ce_in) begin
      clamp_q    <= clamp_q ^ at_pos(hcount_q, half_pos(act_q[11], 1'b0))
                            ^ at_pos(hcount_q, half_pos(act_q[11], 1'b1));
      preblank_q <= preblank_q ^ at_pos(hcount_q, half_pos(act_q[12], 1'b0))
                               ^ at_pos(hcount_q, half_pos(act_q[12], 1'b1));
    end
  end

  // Repeat-area region from starts A, B, C; 8191 never matches a 14-bit count below it
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || (ce_in && line_start_in)) begin
      region_q <= 2'd0;
    end else if (ce_in && mode_q == BLANK_MODE1) begin
      if (at_pos(hcount_q, half_pos(act_q[8], 1'b0))) region_q <= 2'd1;
      else if (at_pos(hcount_q, half_pos(act_q[8], 1'b1))) region_q <= 2'd2;
      else if (at_pos(hcount_q, half_pos(act_q[9], 1'b0))) region_q <= 2'd3;
    end
  end

  // Area walker: each area lasts its phase 1 repeat count of pixels
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || (ce_in && line_start_in)) begin
      area_st_q  <= AREA_IDLE;
      area_q     <= '0;
      area_cnt_q <= '0;
    end else if (ce_in && mode_q == BLANK_MODE1) begin
      unique case (area_st_q)
        AREA_IDLE: begin
          if (blank_q) area_st_q <= AREA_RUN;
        end
        AREA_RUN: begin
          if (!blank_q) begin
            area_st_q <= AREA_DONE;
          end else if (area_cnt_q + 1'b1 >= phase1_rep) begin
            area_cnt_q <= '0;
            if (area_q == 3'(NUM_AREA - 1)) area_st_q <= AREA_DONE;
            else area_q <= area_q + 1'b1;
          end else begin
            area_cnt_q <= area_cnt_q + 1'b1;
          end
        end
        AREA_DONE: area_st_q <= AREA_DONE;
      endcase
    end
  end

  // Free horizontal clock, held at the masking level inside blanking
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) hclk_q <= 1'b0;
    else if (ce_in) hclk_q <= blank_q ? mask_pol_h1 : ~hclk_q;
  end

  // Freeze per group, gated by the line-parity mask
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      frozen_q <= '0;
    end else if (ce_in) begin
      for (int g = 0; g < NUM_GRP; g++) begin
        if (grp_mask[g] && at_pos(hcount_q, freeze_pos_in)) frozen_q[g] <= 1'b1;
        else if (grp_mask[g] && at_pos(hcount_q, resume_pos_in)) frozen_q[g] <= 1'b0;
      end
    end
  end

  // Pattern, phase 2 count and offset outputs registered once more for clean timing; repeat_area_out comes straight from area_q
  logic [PAT_W-1:0] pat_q;
  logic [POS_W-1:0] rep2_q;
  logic [OFS_W-1:0] offset_q;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pat_q    <= '0;
      rep2_q   <= '0;
      offset_q <= '0;
    end else if (ce_in) begin
      pat_q    <= odd_line_in ? act_q[10][32'(area_q) * PAT_STRIDE +: PAT_W] : '0;
      rep2_q   <= phase2_rep;
      offset_q <= (mode_q == BLANK_MODE1 && region_q != 2'd0)
                  ? (odd_line_in ? offset_reg[OFS_HI_LSB +: OFS_W] : offset_reg[0 +: OFS_W])
                  : '0;
    end
  end

  assign rdata_out                     = rdata_q;
  assign horizontal_blanking_out       = hblank_q;
  assign optical_black_clamp_pulse_out = clamp_q;
  assign preblanking_pulse_out         = preblank_q;
  assign odd_phase_hclocks_out         = hclk_q;
  assign group_frozen_out              = frozen_q;
  assign repeat_area_pattern_out       = pat_q;
  assign repeat_area_out               = area_q;
  assign area_phase2_repeat_count_out  = rep2_q;
  assign hclock_offset_out             = offset_q;

  // Assertions
  sequence s_pend_differs;
    pend_q[11] != act_q[11];
  endsequence
  sequence s_no_scp;
    !seq_change_point_in;
  endsequence

  a_shadow_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (ce_in and s_no_scp) |=> act_q[11] == $past(act_q[11]))
    else $error("active copy moved without a change point");
  a_shadow_load: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    ((ce_in && seq_change_point_in) and s_pend_differs) |=> act_q[11] == $past(pend_q[11]))
    else $error("change point did not load the active copy");
  a_clamp_toggle: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (ce_in && !line_start_in && at_pos(hcount_q, half_pos(act_q[11], 1'b0))
     && half_pos(act_q[11], 1'b0) != half_pos(act_q[11], 1'b1))
    |=> clamp_q != $past(clamp_q))
    else $error("clamp did not toggle at its position");
  a_preblank_toggle: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (ce_in && !line_start_in && at_pos(hcount_q, half_pos(act_q[12], 1'b1))
     && half_pos(act_q[12], 1'b0) != half_pos(act_q[12], 1'b1))
    |=> preblank_q != $past(preblank_q))
    else $error("preblank did not toggle at its position");
  a_hclk_masked: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (ce_in && blank_q) |=> hclk_q == $past(mask_pol_h1))
    else $error("hclock not at masking level in blanking");
  a_freeze_masked: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (ce_in && grp_mask == '0) |=> frozen_q == $past(frozen_q))
    else $error("unmasked group changed freeze state");
  a_blank_start: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (ce_in && !line_start_in && at_pos(hcount_q, blank_start)) |=> blank_q)
    else $error("blanking did not open at start");
  a_blank_mode1: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (ce_in && mode_q == BLANK_MODE1 && !line_start_in) |=> hblank_q == $past(blank_q))
    else $error("mode 1 output does not follow interval");
  a_read_pulse: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (ce_in && !rd_in) |=> rdata_out == '0)
    else $error("read data present without a read");
  // Line start clears the counter and every per-line pulse
  a_line_clear: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (ce_in && line_start_in) |=> hcount_q == '0 && !hblank_q && !clamp_q && !preblank_q)
    else $error("line start did not clear line state");
  a_hblank_toggle: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (ce_in && mode_q == BLANK_MODE0 && !line_start_in && ^tog_hit) |=> hblank_q != $past(hblank_q))
    else $error("blanking did not toggle at its position");
  a_region_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (ce_in && mode_q == BLANK_MODE0 && !line_start_in) |=> region_q == $past(region_q))
    else $error("repeat region moved in mode 0");
  a_offset_mode0: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (ce_in && mode_q == BLANK_MODE0) |=> hclock_offset_out == '0)
    else $error("hclock offset applied in mode 0");
  a_pattern_even: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (ce_in && !odd_line_in) |=> repeat_area_pattern_out == '0)
    else $error("odd-line pattern shown on an even line");
  // Freeze wins over resume for the masked groups only
  a_freeze_set: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (ce_in && at_pos(hcount_q, freeze_pos_in))
    |=> frozen_q == ($past(frozen_q) | $past(grp_mask)))
    else $error("masked groups not frozen at freeze position");
  a_hclk_free: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (ce_in && !blank_q) |=> hclk_q != $past(hclk_q))
    else $error("hclock stalled outside blanking");
endmodule

/* File: testbench/ccd_sensor_model.sv */
`timescale 1ns/10ps
// Sensor side of the blanking, clamp and preblank pins; measures each line's pulses
module ccd_sensor_model (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             line_start_in,
  input  wire logic [2:0]       pins_in,
  output logic      [2:0][15:0] rise_pos_out,
  output logic      [2:0][15:0] width_out,
  output logic      [2:0][15:0] rises_out
);
  logic [15:0]      pix_q;
  logic [2:0]       prev_q;
  logic [2:0][15:0] start_q;

  // Pixel count from line start; widths in clock cycles, so latency cancels out
  always_ff @(posedge clk_in) begin
    if (rst_in || line_start_in) begin
      pix_q        <= 16'h0000;
      rise_pos_out <= '0;
      width_out    <= '0;
      rises_out    <= '0;
    end else begin
      pix_q <= pix_q + 16'h0001;
      for (int i = 0; i < 3; i++) begin
        if (pins_in[i] && !prev_q[i]) begin
          rises_out[i]    <= rises_out[i] + 16'h0001;
          rise_pos_out[i] <= pix_q;
          start_q[i]      <= pix_q;
        end
        if (!pins_in[i] && prev_q[i]) begin
          width_out[i] <= pix_q - start_q[i];
        end
      end
    end
    prev_q <= pins_in;
  end
endmodule

/* File: testbench/ccd_line_blanking_tb.sv */
`timescale 1ns/10ps
`define CHECK(name, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got); \
    end \
  end
module ccd_line_blanking_tb;
  import ccd_hblank_pkg::*;
  logic              ref_clk_in    = 1'b0;
  logic              rst_in        = 1'b1;
  logic              ce_in         = 1'b1;
  logic              wr_in         = 1'b0;
  logic              rd_in         = 1'b0;
  logic              line_start_in = 1'b0;
  logic              odd_line_in   = 1'b0;
  logic              sequence_change_point           = 1'b0;
  logic [ADDR_W-1:0] addr_in       = '0;
  logic [DATA_W-1:0] wdata_in      = '0;
  logic [DATA_W-1:0] rdata_out;
  logic              hb, clamp, preblank, hclk;
  logic [NUM_GRP-1:0] group_frozen_out;
  logic [PAT_W-1:0]  pattern;
  logic [2:0]        area;
  logic [POS_W-1:0]  rep2;
  logic [OFS_W-1:0]  offset;
  logic [2:0][15:0]  rise_pos, width, rises;
  int                miscompares   = 0;
  int                comparisons   = 0;

  ccd_line_blanking u_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .line_start_in(line_start_in), .odd_line_in(odd_line_in),
    .seq_change_point_in(sequence_change_point), .freeze_pos_in(13'd15), .resume_pos_in(13'd40),
    .horizontal_blanking_out(hb), .optical_black_clamp_pulse_out(clamp),
    .preblanking_pulse_out(preblank), .odd_phase_hclocks_out(hclk),
    .group_frozen_out(group_frozen_out), .repeat_area_pattern_out(pattern),
    .repeat_area_out(area), .area_phase2_repeat_count_out(rep2), .hclock_offset_out(offset));
  ccd_sensor_model u_sensor (.clk_in(ref_clk_in), .rst_in(rst_in),
    .line_start_in(line_start_in), .pins_in({preblank, clamp, hb}),
    .rise_pos_out(rise_pos), .width_out(width), .rises_out(rises));

  // 125 MHz clock
  always #4 ref_clk_in = ~ref_clk_in;

  // Verdict and end of run, shared by the watchdog
  task automatic final_report;
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Bus cycles; strobes are one cycle and launched right after an edge
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge ref_clk_in);
    wr_in    <= 1'b0;
  endtask
  task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge ref_clk_in);
    rd_in   <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic pulse_scp;
    @(posedge ref_clk_in);
    sequence_change_point <= 1'b1;
    @(posedge ref_clk_in);
    sequence_change_point <= 1'b0;
  endtask
  // Line start; returns just after the edge that takes it
  task automatic line_go(input logic odd);
    @(posedge ref_clk_in);
    line_start_in <= 1'b1;
    odd_line_in   <= odd;
    @(posedge ref_clk_in);
    line_start_in <= 1'b0;
    #1;
  endtask
  // Ascending random toggle list; unused slots never match
  task automatic gen(output int p[6], input int n);
    for (int i = 0; i < 6; i++) begin
      p[i] = (i == 0) ? 2 + $urandom_range(7) : (i < n ? p[i-1] + 3 + $urandom_range(7) : 8191);
    end
  endtask
  // Rises, last rise pixel and last width of a toggle list
  function automatic logic [47:0] exp_pulse(input int p[6]);
    int c;
    c = 0;
    foreach (p[i]) if (p[i] != 8191) c++;
    return {16'((c + 1) / 2), 16'(p[c-2] + 1), 16'(p[c-1] - p[c-2])};
  endfunction

  // Watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    miscompares++;
    final_report;
  end

  initial begin
    int                po[6], pe[6], pc[6], pb[6];
    logic [DATA_W-1:0] d, w;
    logic [3:0]        me;
    logic [2:0]        pat;
    logic [12:0]       r2;
    logic [11:0]       oa;
    logic              pol;
    void'($urandom(32'hFD86));
    repeat (10) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    // Reset values and writable bits of every sequence register
    for (int a = 'h17; a <= 'h27; a++) begin
      reg_rd(6'(a), d);
      `CHECK("reset value", SEQ_RESET, d);
      w = 26'($urandom);
      reg_wr(6'(a), w);
      reg_rd(6'(a), d);
      `CHECK("readback", w & SEQ_MASK[a - 'h17], d);
    end
    tick(1);
    `CHECK("read data stands one cycle", 26'h0, rdata_out);
    reg_rd(6'h3F, d);
    `CHECK("unmapped read", 26'h0, d);
    // Enable low freezes state, so this write must not land
    @(posedge ref_clk_in);
    ce_in <= 1'b0;
    reg_wr(OFS_BLANK_CNT_START, ~w);
    ce_in <= 1'b1;
    reg_rd(OFS_BLANK_CNT_START, d);
    `CHECK("write with enable low", w & SEQ_MASK[16], d);
    // Mode 0 set-up; unused starts and counter parked at the never value
    gen(po, 6);
    gen(pe, 4);
    gen(pc, 2);
    gen(pb, 2);
    me = 4'($urandom);
    reg_wr(OFS_CONTROL, 26'h0);
    reg_wr(OFS_BLANK_START_END, {NEVER_POS, NEVER_POS});
    reg_wr(OFS_BLANK_LEN_REP, 26'h0);
    for (int k = 0; k < 3; k++) begin
      reg_wr(OFS_ODD_TOGGLE_1_2 + 6'(k), {13'(po[2*k+1]), 13'(po[2*k])});
      reg_wr(OFS_EVEN_TOGGLE_1_2 + 6'(k), {13'(pe[2*k+1]), 13'(pe[2*k])});
    end
    reg_wr(OFS_AREA_START_A_B, {NEVER_POS, NEVER_POS});
    reg_wr(OFS_AREA_START_C_MASK, {5'h00, ~me, me, NEVER_POS});
    reg_wr(OFS_BLACK_CLAMP_TOG, {13'(pc[1]), 13'(pc[0])});
    reg_wr(OFS_PREBLANK_TOG, {13'(pb[1]), 13'(pb[0])});
    reg_wr(OFS_BLANK_CNT_START, 26'h1FFF);
    // Written values must wait for the change point
    line_go(1'b1);
    tick(75);
    `CHECK("no early use", 48'h0, rises);
    pulse_scp;
    line_go(1'b1);
    tick(25);
    `CHECK("frozen odd", ~me, group_frozen_out);
    tick(50);
    `CHECK("resumed odd", 4'h0, group_frozen_out);
    `CHECK("blanking odd", exp_pulse(po), {rises[0], rise_pos[0], width[0]});
    `CHECK("clamp", exp_pulse(pc), {rises[1], rise_pos[1], width[1]});
    `CHECK("preblank", exp_pulse(pb), {rises[2], rise_pos[2], width[2]});
    line_go(1'b0);
    tick(25);
    `CHECK("frozen even", me, group_frozen_out);
    tick(50);
    `CHECK("blanking even", exp_pulse(pe), {rises[0], rise_pos[0], width[0]});
    // Mode 1: interval 20..50, area 0 held long, region A from 25
    pol = 1'($urandom);
    pat = 3'($urandom);
    r2  = 13'($urandom);
    oa  = 12'($urandom);
    reg_wr(OFS_CONTROL, 26'h1);
    reg_rd(OFS_CONTROL, d);
    `CHECK("mode readback", 26'h1, d);
    reg_wr(OFS_BLANK_START_END, {13'd50, 13'd20});
    reg_wr(OFS_BLANK_LEN_REP, 26'(pol) << MASK_H1_BIT);
    reg_wr(OFS_BLANK_CNT_START, 26'd20);
    reg_wr(OFS_ODD_TOGGLE_1_2, 26'd200);
    reg_wr(OFS_EVEN_TOGGLE_1_2, 26'(r2));
    reg_wr(OFS_AREA_PATTERNS_ODD, 26'(pat));
    reg_wr(OFS_AREA_START_A_B, {NEVER_POS, 13'd25});
    reg_wr(OFS_HCLOCK_OFFSET_A, {2'b00, oa, ~oa});
    pulse_scp;
    line_go(1'b1);
    tick(35);
    `CHECK("hclock masking", pol, hclk);
    `CHECK("area", 3'h0, area);
    `CHECK("area pattern", pat, pattern);
    `CHECK("phase2 count", r2, rep2);
    `CHECK("hclock offset", oa, offset);
    tick(40);
    `CHECK("mode1 interval", {16'h1, 16'd22, 16'd30}, {rises[0], rise_pos[0], width[0]});
    // End position bit 13 pushes the end beyond the line
    reg_wr(OFS_BLANK_CNT_START, 26'h2014);
    pulse_scp;
    line_go(1'b1);
    tick(75);
    `CHECK("wide end", {1'b1, 16'h0}, {hb, width[0]});
    final_report;
  end
endmodule
